//--- sdpf_pkg.sv
// constants, record layout and state type for the data page formatter
package sdpf_pkg;
   // ==========================================================
   // task file addresses
   localparam logic [8:0] ADDR_ERR  = 9'h1F1;
   localparam logic [8:0] ADDR_FEAT = 9'h1F1;
   localparam logic [8:0] ADDR_SC   = 9'h1F2;
   localparam logic [8:0] ADDR_SN   = 9'h1F3;
   localparam logic [8:0] ADDR_CL   = 9'h1F4;
   localparam logic [8:0] ADDR_CH   = 9'h1F5;
   localparam logic [8:0] ADDR_DH   = 9'h1F6;
   localparam logic [8:0] ADDR_ST   = 9'h1F7;
   localparam logic [8:0] ADDR_CMD  = 9'h1F7;
   // ==========================================================
   // command and subcommand codes, status signatures
   localparam logic [7:0] CMD_SMART    = 8'hB0;
   localparam logic [7:0] SUB_RD_VAL   = 8'hD0;
   localparam logic [7:0] SUB_RD_THR   = 8'hD1;
   localparam logic [7:0] SUB_RET_STAT = 8'hDA;
   localparam logic [7:0] KEY_CL       = 8'h4F;
   localparam logic [7:0] KEY_CH       = 8'hC2;
   localparam logic [7:0] FAIL_CL      = 8'hF4;
   localparam logic [7:0] FAIL_CH      = 8'h2C;
   // ==========================================================
   // status and error bits
   localparam int ST_BSY     = 7;
   localparam int ST_DRDY    = 6;
   localparam int ST_DRQ     = 3;
   localparam int ST_ERR     = 0;
   localparam int ERR_ABRT   = 2;
   localparam int DH_DV_BIT  = 4;
   // ==========================================================
   // page layout
   localparam logic [15:0] FORMAT_VERSION = 16'h0001;
   localparam logic [8:0]  VER_LO       = 9'h000;
   localparam logic [8:0]  VER_HI       = 9'h001;
   localparam logic [8:0]  ENTRY_FIRST  = 9'h002;
   localparam logic [8:0]  ENTRY_LAST   = 9'h169;
   localparam logic [8:0]  CAP_LO       = 9'h170;
   localparam logic [8:0]  PAGE_LAST    = 9'h1FF;
   localparam logic [3:0]  OFS_ID       = 4'h0;
   localparam logic [3:0]  OFS_FLAG_LO  = 4'h1;
   localparam logic [3:0]  OFS_THR      = 4'h1;
   localparam logic [3:0]  OFS_CUR      = 4'h3;
   localparam logic [3:0]  OFS_WORST    = 4'h4;
   localparam logic [3:0]  OFS_RAW_LO   = 4'h5;
   localparam logic [3:0]  OFS_RAW_HI   = 4'hA;
   localparam logic [3:0]  OFS_LAST     = 4'hB;
   localparam logic [4:0]  NUM_ENTRIES  = 5'h1E;
   localparam logic [4:0]  LAST_ENTRY   = 5'h1D;
   localparam logic [7:0]  VAL_MIN      = 8'h01;
   localparam logic [7:0]  VAL_MAX      = 8'h64;
   // ==========================================================
   // attribute record held in the record memory
   localparam int REC_ID    = 0;
   localparam int REC_FLAG  = 8;
   localparam int REC_CUR   = 9;
   localparam int REC_WORST = 17;
   localparam int REC_RAW   = 25;
   localparam int REC_THR   = 73;
   localparam int REC_W     = 81;
   localparam int RAM_AW    = 5;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   // ==========================================================
   // controller states
   typedef enum logic [3:0] {
      S_IDLE     = 4'h0,
      S_SAVE     = 4'h1,
      S_SCAN_RD  = 4'h2,
      S_SCAN_CHK = 4'h3,
      S_GEN      = 4'h4,
      S_LOAD     = 4'h5,
      S_DRAIN    = 4'h6,
      S_UPD_RD   = 4'h7,
      S_UPD_WR   = 4'h8
   } sdpf_state_t;
endpackage

//--- sdpf_rec_ram.sv
// attribute record memory with registered read data
`timescale 1ns/1ns
module sdpf_rec_ram #(
   parameter int W  = 81,
   parameter int AW = 5
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          arst_n,
   // write side
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [W-1:0]  wr_data,
   // read side
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [W-1:0]  rd_data
);
   logic [W-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // read data hold until the next read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

//--- sdpf_formatter.sv
// failure-prediction data page formatter behind the task file
// ==========================================================
// Function
// [RULE_01] subcommand D0h returns the 512-byte attribute value page
// [RULE_02] subcommand D1h returns the 512-byte threshold page
// [RULE_03] bytes 00-01 of both pages carry the same format version
// [RULE_04] version is one constant, changed only when the layout changes
// [RULE_05] entry 1 at 02-0D: id, flags, current, worst, raw, reserved
// [RULE_06] entries 2 to 30 repeat the twelve-byte layout up to 169
// [RULE_07] attribute page: reserved, capability word at 170, reserved, vendor bytes
// [RULE_08] byte 1FF is two's complement of the sum of bytes 0 to 1FE
// [RULE_09] threshold entry: id at 02, threshold at 03, rest reserved; tail layout
// [RULE_10] id 0 marks unused entry; other ids are stored as given
// [RULE_11] status flag bit 0 tells how a threshold crossing reads; others zero
// [RULE_12] current value is clamped to 01h through 64h; lower is worse
// [RULE_13] normal only while current value is strictly above its threshold
// [RULE_14] worst byte keeps the lowest value seen, updated when worse
// [RULE_15] raw field keeps the unnormalized collected data
// [RULE_16] capability bit 0 reports save before power saving
// [RULE_17] capability bit 1 reports automatic save; bits 2-15 zero
// [RULE_18] host judges failure by comparing values with thresholds
// [RULE_19] return status loads 4Fh/C2h when healthy, F4h/2Ch otherwise
// [RULE_20] value read first saves under busy, then transfers the page
// [RULE_21] multi-byte fields are placed low byte first
`timescale 1ns/1ns
module sdpf_formatter #(
   parameter logic DRIVE_SEL = 1'b0
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // task file access
   input  wire logic [8:0]  tf_addr,
   input  wire logic        tf_wr,
   input  wire logic        tf_rd,
   input  wire logic [7:0]  tf_wdata,
   output logic      [7:0]  tf_rdata_r,
   // page data stream to the host
   output logic             pio_valid,
   input  wire logic        pio_ready,
   output logic      [15:0] pio_data,
   // attribute collection and configuration
   input  wire logic        upd_valid,
   output logic             upd_ready,
   input  wire logic        upd_cfg,
   input  wire logic [4:0]  upd_index,
   input  wire logic [7:0]  upd_id,
   input  wire logic        upd_flag,
   input  wire logic [7:0]  upd_thr,
   input  wire logic [7:0]  upd_value,
   input  wire logic [47:0] upd_raw,
   // media save handshake
   output logic             save_req,
   input  wire logic        save_done,
   // capability straps
   input  wire logic        cap_save_powersave,
   input  wire logic        cap_autosave
);
   // ==========================================================
   // helpers
   function automatic logic in_entry(input logic [8:0] idx);
      in_entry = (idx >= sdpf_pkg::ENTRY_FIRST) && (idx <= sdpf_pkg::ENTRY_LAST);
   endfunction

   function automatic logic [7:0] clamp_val(input logic [7:0] v);
      if (v < sdpf_pkg::VAL_MIN) begin
         clamp_val = sdpf_pkg::VAL_MIN;
      end else if (v > sdpf_pkg::VAL_MAX) begin
         clamp_val = sdpf_pkg::VAL_MAX;
      end else begin
         clamp_val = v;
      end
   endfunction

   function automatic logic entry_fails(input logic [sdpf_pkg::REC_W-1:0] rec);
      logic [7:0] id;
      logic [7:0] cur;
      logic [7:0] thr;
      id  = rec[sdpf_pkg::REC_ID +: 8];
      cur = rec[sdpf_pkg::REC_CUR +: 8];
      thr = rec[sdpf_pkg::REC_THR +: 8];
      entry_fails = (id != 8'h00) && (cur <= thr); // RULE_13
   endfunction

   function automatic logic [7:0] page_byte(
      input logic                        thr_page,
      input logic [8:0]                  idx,
      input logic [3:0]                  ofs,
      input logic [sdpf_pkg::REC_W-1:0]  rec,
      input logic [1:0]                  cap,
      input logic [7:0]                  sum
   );
      logic [7:0] b;
      int         k;
      b = 8'h00;
      k = 0;
      if (idx == sdpf_pkg::VER_LO) begin
         b = sdpf_pkg::FORMAT_VERSION[7:0]; // RULE_03 RULE_04 RULE_21
      end else if (idx == sdpf_pkg::VER_HI) begin
         b = sdpf_pkg::FORMAT_VERSION[15:8]; // RULE_03 RULE_04
      end else if (in_entry(idx)) begin
         if (thr_page) begin
            if (ofs == sdpf_pkg::OFS_ID) begin
               b = rec[sdpf_pkg::REC_ID +: 8]; // RULE_09 RULE_10
            end else if (ofs == sdpf_pkg::OFS_THR) begin
               b = rec[sdpf_pkg::REC_THR +: 8]; // RULE_09
            end
         end else begin
            if (ofs == sdpf_pkg::OFS_ID) begin
               b = rec[sdpf_pkg::REC_ID +: 8]; // RULE_05 RULE_10
            end else if (ofs == sdpf_pkg::OFS_FLAG_LO) begin
               b = {7'h00, rec[sdpf_pkg::REC_FLAG]}; // RULE_11 RULE_21
            end else if (ofs == sdpf_pkg::OFS_CUR) begin
               b = rec[sdpf_pkg::REC_CUR +: 8]; // RULE_05
            end else if (ofs == sdpf_pkg::OFS_WORST) begin
               b = rec[sdpf_pkg::REC_WORST +: 8]; // RULE_05
            end else if (ofs >= sdpf_pkg::OFS_RAW_LO && ofs <= sdpf_pkg::OFS_RAW_HI) begin
               k = 8 * (int'(ofs) - int'(sdpf_pkg::OFS_RAW_LO));
               b = rec[sdpf_pkg::REC_RAW + k +: 8]; // RULE_15 RULE_21
            end
         end
      end else if (!thr_page && idx == sdpf_pkg::CAP_LO) begin
         b = {6'h00, cap}; // RULE_07 RULE_16 RULE_17
      end else if (idx == sdpf_pkg::PAGE_LAST) begin
         b = 8'h00 - sum; // RULE_08
      end
      page_byte = b;
   endfunction

   // ==========================================================
   // declarations
   sdpf_pkg::sdpf_state_t state_r;
   logic [7:0]  sc_r;
   logic [7:0]  sn_r;
   logic [7:0]  cl_r;
   logic [7:0]  ch_r;
   logic [7:0]  dh_r;
   logic [7:0]  feat_r;
   logic [7:0]  err_r;
   logic        st_err_r;
   logic        thr_page_r;
   logic        stat_mode_r;
   logic        fail_r;
   logic        loaded_r;
   logic [8:0]  byte_r;
   logic [3:0]  ofs_r;
   logic [4:0]  ent_r;
   logic [7:0]  sum_r;
   logic [7:0]  lo_r;
   logic        h_cfg_r;
   logic [4:0]  h_idx_r;
   logic [7:0]  h_id_r;
   logic        h_flag_r;
   logic [7:0]  h_thr_r;
   logic [7:0]  h_val_r;
   logic [47:0] h_raw_r;
   logic [15:0] buf_mem [0:1];
   logic        buf_wp_r;
   logic        buf_rp_r;
   logic [1:0]  buf_cnt_r;
   logic [sdpf_pkg::REC_W-1:0] ram_rdata;
   logic [sdpf_pkg::REC_W-1:0] new_rec;
   logic        xfer;
   logic        bsy;
   logic [7:0]  status;
   logic        cmd_take;
   logic        cmd_ok;
   logic        tf_idle_wr;
   logic        need_load;
   logic        buf_in_ready;
   logic        byte_go;
   logic        buf_push;
   logic        buf_pop;
   logic [7:0]  cur_byte;
   logic        stat_done;
   logic        stat_fail;
   logic        ram_rd_en;
   logic        ram_wr_en;
   logic [4:0]  ram_rd_addr;
   logic [7:0]  clamped;
   logic [7:0]  old_worst;

   // ==========================================================
   // command decode and status
   assign xfer       = (state_r == sdpf_pkg::S_GEN) || (state_r == sdpf_pkg::S_LOAD) ||
                       (state_r == sdpf_pkg::S_DRAIN);
   assign bsy        = (state_r != sdpf_pkg::S_IDLE) && !xfer; // RULE_20
   assign status     = {bsy, !bsy, 2'h0, xfer, 2'h0, st_err_r};
   assign tf_idle_wr = tf_wr && (state_r == sdpf_pkg::S_IDLE);
   assign cmd_take   = tf_idle_wr && (tf_addr == sdpf_pkg::ADDR_CMD) &&
                       (dh_r[sdpf_pkg::DH_DV_BIT] == DRIVE_SEL);
   assign cmd_ok     = (tf_wdata == sdpf_pkg::CMD_SMART) && (cl_r == sdpf_pkg::KEY_CL) &&
                       (ch_r == sdpf_pkg::KEY_CH) &&
                       ((feat_r == sdpf_pkg::SUB_RD_VAL) || (feat_r == sdpf_pkg::SUB_RD_THR) ||
                        (feat_r == sdpf_pkg::SUB_RET_STAT));
   assign upd_ready  = (state_r == sdpf_pkg::S_IDLE) && !cmd_take;
   assign save_req   = (state_r == sdpf_pkg::S_SAVE); // RULE_20
   assign stat_done  = (state_r == sdpf_pkg::S_SCAN_CHK) && (ent_r == sdpf_pkg::LAST_ENTRY);
   assign stat_fail  = fail_r || entry_fails(ram_rdata);

   // ==========================================================
   // page generation datapath
   assign need_load    = in_entry(byte_r) && !loaded_r;
   assign buf_in_ready = (buf_cnt_r != sdpf_pkg::BUF_DEPTH);
   assign byte_go      = (state_r == sdpf_pkg::S_GEN) && !need_load &&
                         (!byte_r[0] || buf_in_ready);
   assign buf_push     = byte_go && byte_r[0];
   assign buf_pop      = pio_valid && pio_ready;
   assign cur_byte     = page_byte(thr_page_r, byte_r, ofs_r, ram_rdata,
                                   {cap_autosave, cap_save_powersave}, sum_r);

   // ==========================================================
   // record memory access
   assign ram_rd_en   = (state_r == sdpf_pkg::S_LOAD) || (state_r == sdpf_pkg::S_SCAN_RD) ||
                        (state_r == sdpf_pkg::S_UPD_RD);
   assign ram_rd_addr = (state_r == sdpf_pkg::S_UPD_RD) ? h_idx_r : ent_r;
   assign ram_wr_en   = (state_r == sdpf_pkg::S_UPD_WR);
   assign clamped     = clamp_val(h_val_r); // RULE_12
   assign old_worst   = ram_rdata[sdpf_pkg::REC_WORST +: 8];

   always_comb begin
      new_rec = ram_rdata;
      if (h_cfg_r) begin
         new_rec[sdpf_pkg::REC_ID +: 8]    = h_id_r; // RULE_10
         new_rec[sdpf_pkg::REC_FLAG]       = h_flag_r; // RULE_11
         new_rec[sdpf_pkg::REC_THR +: 8]   = h_thr_r;
         new_rec[sdpf_pkg::REC_CUR +: 8]   = sdpf_pkg::VAL_MAX;
         new_rec[sdpf_pkg::REC_WORST +: 8] = sdpf_pkg::VAL_MAX;
         new_rec[sdpf_pkg::REC_RAW +: 48]  = 48'h000000000000;
      end else begin
         new_rec[sdpf_pkg::REC_CUR +: 8]   = clamped; // RULE_12
         new_rec[sdpf_pkg::REC_WORST +: 8] = clamped < old_worst ? clamped : old_worst; // RULE_14
         new_rec[sdpf_pkg::REC_RAW +: 48]  = h_raw_r; // RULE_15
      end
   end

   sdpf_rec_ram #(
      .W  (sdpf_pkg::REC_W),
      .AW (sdpf_pkg::RAM_AW)
   ) u_ram (
      .clk     (clk),
      .arst_n  (arst_n),
      .wr_en   (ram_wr_en),
      .wr_addr (h_idx_r),
      .wr_data (new_rec),
      .rd_en   (ram_rd_en),
      .rd_addr (ram_rd_addr),
      .rd_data (ram_rdata)
   );

   // ==========================================================
   // task file registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sc_r     <= 8'h00;
         sn_r     <= 8'h00;
         cl_r     <= 8'h00;
         ch_r     <= 8'h00;
         dh_r     <= 8'h00;
         feat_r   <= 8'h00;
         err_r    <= 8'h00;
         st_err_r <= 1'b0;
      end else begin
         if (tf_idle_wr) begin
            case (tf_addr)
               sdpf_pkg::ADDR_FEAT: feat_r <= tf_wdata;
               sdpf_pkg::ADDR_SC:   sc_r   <= tf_wdata;
               sdpf_pkg::ADDR_SN:   sn_r   <= tf_wdata;
               sdpf_pkg::ADDR_CL:   cl_r   <= tf_wdata;
               sdpf_pkg::ADDR_CH:   ch_r   <= tf_wdata;
               sdpf_pkg::ADDR_DH:   dh_r   <= tf_wdata;
               default: begin
               end
            endcase
         end
         if (cmd_take) begin
            err_r    <= cmd_ok ? 8'h00 : (8'h01 << sdpf_pkg::ERR_ABRT);
            st_err_r <= !cmd_ok;
         end
         if (stat_done) begin
            cl_r <= stat_fail ? sdpf_pkg::FAIL_CL : sdpf_pkg::KEY_CL; // RULE_19
            ch_r <= stat_fail ? sdpf_pkg::FAIL_CH : sdpf_pkg::KEY_CH; // RULE_19
         end
      end
   end

   // read answer one cycle after the strobe
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tf_rdata_r <= 8'h00;
      end else if (tf_rd) begin
         case (tf_addr)
            sdpf_pkg::ADDR_ERR: tf_rdata_r <= err_r;
            sdpf_pkg::ADDR_SC:  tf_rdata_r <= sc_r;
            sdpf_pkg::ADDR_SN:  tf_rdata_r <= sn_r;
            sdpf_pkg::ADDR_CL:  tf_rdata_r <= cl_r;
            sdpf_pkg::ADDR_CH:  tf_rdata_r <= ch_r;
            sdpf_pkg::ADDR_DH:  tf_rdata_r <= dh_r;
            sdpf_pkg::ADDR_ST:  tf_rdata_r <= status;
            default:            tf_rdata_r <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // controller
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r     <= sdpf_pkg::S_IDLE;
         thr_page_r  <= 1'b0;
         stat_mode_r <= 1'b0;
         fail_r      <= 1'b0;
         loaded_r    <= 1'b0;
         byte_r      <= 9'h000;
         ofs_r       <= 4'h0;
         ent_r       <= 5'h00;
         sum_r       <= 8'h00;
      end else begin
         case (state_r)
            sdpf_pkg::S_IDLE: begin
               if (cmd_take && cmd_ok) begin
                  thr_page_r  <= (feat_r == sdpf_pkg::SUB_RD_THR);
                  stat_mode_r <= (feat_r == sdpf_pkg::SUB_RET_STAT);
                  fail_r      <= 1'b0;
                  loaded_r    <= 1'b0;
                  byte_r      <= 9'h000;
                  ofs_r       <= 4'h0;
                  ent_r       <= 5'h00;
                  sum_r       <= 8'h00;
                  if (feat_r == sdpf_pkg::SUB_RD_THR) begin
                     state_r <= sdpf_pkg::S_GEN; // RULE_02
                  end else begin
                     state_r <= sdpf_pkg::S_SAVE; // RULE_20
                  end
               end else if (upd_valid && upd_ready && upd_index < sdpf_pkg::NUM_ENTRIES) begin
                  state_r <= sdpf_pkg::S_UPD_RD;
               end
            end
            sdpf_pkg::S_SAVE: begin
               if (save_done) begin
                  state_r <= stat_mode_r ? sdpf_pkg::S_SCAN_RD : sdpf_pkg::S_GEN; // RULE_01
               end
            end
            sdpf_pkg::S_SCAN_RD: begin
               state_r <= sdpf_pkg::S_SCAN_CHK;
            end
            sdpf_pkg::S_SCAN_CHK: begin
               fail_r <= stat_fail; // RULE_13
               if (ent_r == sdpf_pkg::LAST_ENTRY) begin
                  state_r <= sdpf_pkg::S_IDLE;
               end else begin
                  ent_r   <= ent_r + 5'h01;
                  state_r <= sdpf_pkg::S_SCAN_RD;
               end
            end
            sdpf_pkg::S_GEN: begin
               if (need_load) begin
                  state_r <= sdpf_pkg::S_LOAD;
               end else if (byte_go) begin
                  sum_r  <= sum_r + cur_byte; // RULE_08
                  byte_r <= byte_r + 9'h001;
                  if (in_entry(byte_r)) begin
                     if (ofs_r == sdpf_pkg::OFS_LAST) begin
                        ofs_r    <= 4'h0; // RULE_06
                        ent_r    <= ent_r + 5'h01;
                        loaded_r <= 1'b0;
                     end else begin
                        ofs_r <= ofs_r + 4'h1;
                     end
                  end
                  if (byte_r == sdpf_pkg::PAGE_LAST) begin
                     state_r <= sdpf_pkg::S_DRAIN;
                  end
               end
            end
            sdpf_pkg::S_LOAD: begin
               loaded_r <= 1'b1;
               state_r  <= sdpf_pkg::S_GEN;
            end
            sdpf_pkg::S_DRAIN: begin
               if (buf_cnt_r == 2'h0) begin
                  state_r <= sdpf_pkg::S_IDLE;
               end
            end
            sdpf_pkg::S_UPD_RD: begin
               state_r <= sdpf_pkg::S_UPD_WR;
            end
            sdpf_pkg::S_UPD_WR: begin
               state_r <= sdpf_pkg::S_IDLE;
            end
            default: begin
               state_r <= sdpf_pkg::S_IDLE;
            end
         endcase
      end
   end

   // update request hold
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         h_cfg_r  <= 1'b0;
         h_idx_r  <= 5'h00;
         h_id_r   <= 8'h00;
         h_flag_r <= 1'b0;
         h_thr_r  <= 8'h00;
         h_val_r  <= 8'h00;
         h_raw_r  <= 48'h000000000000;
      end else if (upd_valid && upd_ready) begin
         h_cfg_r  <= upd_cfg;
         h_idx_r  <= upd_index;
         h_id_r   <= upd_id;
         h_flag_r <= upd_flag;
         h_thr_r  <= upd_thr;
         h_val_r  <= upd_value;
         h_raw_r  <= upd_raw;
      end
   end

   // ==========================================================
   // byte pairing and two-entry output buffer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lo_r <= 8'h00;
      end else if (byte_go && !byte_r[0]) begin
         lo_r <= cur_byte; // RULE_21
      end
   end

   always_ff @(posedge clk) begin
      if (buf_push) begin
         buf_mem[buf_wp_r] <= {cur_byte, lo_r};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_wp_r  <= 1'b0;
         buf_rp_r  <= 1'b0;
         buf_cnt_r <= 2'h0;
      end else begin
         if (buf_push) begin
            buf_wp_r <= !buf_wp_r;
         end
         if (buf_pop) begin
            buf_rp_r <= !buf_rp_r;
         end
         if (buf_push && !buf_pop) begin
            buf_cnt_r <= buf_cnt_r + 2'h1;
         end else if (buf_pop && !buf_push) begin
            buf_cnt_r <= buf_cnt_r - 2'h1;
         end
      end
   end

   assign pio_valid = (buf_cnt_r != 2'h0);
   assign pio_data  = pio_valid ? buf_mem[buf_rp_r] : 16'h0000;
endmodule

//--- sdpf_checker.sv
// port assertions for the page formatter
`timescale 1ns/1ns
module sdpf_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // watched ports
   input wire logic        pio_valid,
   input wire logic        pio_ready,
   input wire logic [15:0] pio_data,
   input wire logic        upd_valid,
   input wire logic        upd_ready,
   input wire logic        save_req,
   input wire logic        save_done
);
   // ==========================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_idle_zero: assert property (!pio_valid |-> pio_data == 16'h0000)
      else $error("idle data");
   a_stall_hold: assert property (pio_valid && !pio_ready |=> pio_valid && $stable(pio_data))
      else $error("word lost");
   a_save_hold: assert property (save_req && !save_done |=> save_req)
      else $error("save cut");
   a_save_end: assert property (save_req && save_done |=> !save_req)
      else $error("save stuck");
   a_save_quiet: assert property (save_req |-> !pio_valid && !upd_ready)
      else $error("busy save");
   a_first_gap: assert property ($fell(save_req) |-> !pio_valid [*2])
      else $error("early");
   a_upd_busy: assert property (upd_valid && upd_ready |=> !upd_ready [*2])
      else $error("upd");
   a_stream_busy: assert property (pio_valid |-> !upd_ready)
      else $error("idle in stream");
   c_save: cover property ($rose(save_req));
   c_stall: cover property (pio_valid && !pio_ready);
   c_upd: cover property (upd_valid && upd_ready);
endmodule
bind sdpf_formatter sdpf_checker u_chk (.clk, .arst_n, .pio_valid, .pio_ready, .pio_data,
   .upd_valid, .upd_ready, .save_req, .save_done);

//--- sdpf_host_sink.sv
// host side page sink that stalls one cycle in three
`timescale 1ns/1ns
module sdpf_host_sink (
   // clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        clr,
   // page stream
   input wire logic        pio_valid,
   output logic            pio_ready,
   input wire logic [15:0] pio_data,
   // words taken
   output int              n
);
   logic [7:0] pg [512];
   logic [1:0] ph;
   assign pio_ready = ph != 2'h2;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ph <= 2'h0;
         n <= 0;
      end else begin
         ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
         if (clr) n <= 0;
         else if (pio_valid && pio_ready && n < 256) begin
            pg[2*n] <= pio_data[7:0];
            pg[2*n+1] <= pio_data[15:8];
            n <= n + 1;
         end
      end
   end
endmodule

//--- tb_sdpf_formatter.sv
// testbench for the page formatter
`timescale 1ns/1ns
`define CHK(s,e,a) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
   $display("[ERR] %s exp %h got %h", s, e, a); end end
module tb_sdpf_formatter;
   logic        clk = 0, arst_n = 0, tf_wr = 0, tf_rd = 0, clr = 0, save_done = 0;
   logic        upd_valid = 0, upd_cfg = 0, upd_flag = 0, cap_save_powersave = 1, cap_autosave = 0;
   logic        pio_valid, pio_ready, upd_ready, save_req, fl [30];
   logic [8:0]  tf_addr = '0;
   logic [7:0]  tf_wdata = '0, upd_id = '0, upd_thr = '0, upd_value = '0, tf_rdata_r, v;
   logic [7:0]  id [30], thr [30], cur [30], wst [30], e [512];
   logic [4:0]  upd_index = '0;
   logic [47:0] upd_raw = '0, raw [30];
   logic [15:0] pio_data;
   int          n, fail_count = 0, n_tests = 0;
   sdpf_formatter u_dut (.clk, .arst_n, .tf_addr, .tf_wr, .tf_rd, .tf_wdata, .tf_rdata_r,
      .pio_valid, .pio_ready, .pio_data, .upd_valid, .upd_ready, .upd_cfg, .upd_index, .upd_id,
      .upd_flag, .upd_thr, .upd_value, .upd_raw, .save_req, .save_done, .cap_save_powersave,
      .cap_autosave);
   sdpf_host_sink u_host (.clk, .arst_n, .clr, .pio_valid, .pio_ready, .pio_data, .n);
   always #4 clk = ~clk;
   always @(negedge clk) save_done <= save_req;
   task wr(input logic [8:0] a, input logic [7:0] d);
      {tf_addr, tf_wdata, tf_wr} = {a, d, 1'b1};
      @(negedge clk) tf_wr = 0;
      @(negedge clk);
   endtask
   task rd(input logic [8:0] a);
      {tf_addr, tf_rd} = {a, 1'b1};
      @(negedge clk) tf_rd = 0;
      v = tf_rdata_r;
      @(negedge clk);
   endtask
   task upd(input logic c, input int i, input logic [7:0] x);
      {upd_cfg, upd_index, upd_id, upd_flag, upd_thr} = {c, i[4:0], id[i], fl[i], thr[i]};
      {upd_value, upd_raw, upd_valid} = {x, raw[i], 1'b1};
      @(negedge clk) upd_valid = 0;
      repeat (3) @(negedge clk);
   endtask
   task cmd(input logic [7:0] s);
      wr(sdpf_pkg::ADDR_FEAT, s);
      wr(sdpf_pkg::ADDR_CL, sdpf_pkg::KEY_CL);
      wr(sdpf_pkg::ADDR_CH, sdpf_pkg::KEY_CH);
      wr(sdpf_pkg::ADDR_CMD, sdpf_pkg::CMD_SMART);
      v = 8'h80;
      for (int k = 0; k < 2000 && (v[7] | v[3]); k++) rd(sdpf_pkg::ADDR_ST);
      `CHK("idle", 1'b0, v[7] | v[3])
   endtask
   task stat;
      logic b;
      b = 0;
      for (int i = 0; i < 30; i++) b |= id[i] != 8'h00 && cur[i] <= thr[i];
      cmd(sdpf_pkg::SUB_RET_STAT);
      rd(sdpf_pkg::ADDR_CL);
      `CHK("cyl_low", b ? sdpf_pkg::FAIL_CL : sdpf_pkg::KEY_CL, v)
      rd(sdpf_pkg::ADDR_CH);
      `CHK("cyl_high", b ? sdpf_pkg::FAIL_CH : sdpf_pkg::KEY_CH, v)
   endtask
   task page(input logic t);
      logic [7:0] s;
      s = 8'h00;
      e = '{default: 8'h00};
      {e[1], e[0]} = sdpf_pkg::FORMAT_VERSION;
      for (int i = 0; i < 30; i++) begin
         e[2+12*i] = id[i];
         e[3+12*i] = t ? thr[i] : {7'h00, fl[i]};
         if (!t) {e[5+12*i], e[6+12*i]} = {cur[i], wst[i]};
         for (int j = 0; j < 6 && !t; j++) e[7+12*i+j] = raw[i][8*j+:8];
      end
      if (!t) e[9'h170] = {6'h00, cap_autosave, cap_save_powersave};
      for (int k = 0; k < 511; k++) s += e[k];
      e[511] = 8'h00 - s;
      clr = 1;
      @(negedge clk) clr = 0;
      cmd(t ? sdpf_pkg::SUB_RD_THR : sdpf_pkg::SUB_RD_VAL);
      `CHK("words", 256, n)
      for (int k = 0; k < 512; k++) `CHK("byte", e[k], u_host.pg[k])
   endtask
   task results;
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      results();
   end
   initial begin
      repeat (4) @(negedge clk);
      arst_n = 1;
      for (int i = 0; i < 30; i++) begin
         {id[i], thr[i], fl[i]} = {(i == 29) ? 8'hC7 : 8'(i * 7), 8'(i + 1), i[0]};
         {cur[i], wst[i], raw[i]} = {16'h6464, 48'h060504030201 + 48'(i)};
         upd(1, i, 8'h00);
         upd(0, i, 8'h64);
      end
      stat();
      upd(0, 1, 8'h00);
      upd(0, 1, 8'h50);
      upd(0, 2, 8'hFF);
      {cur[1], wst[1], cur[2]} = {8'h50, 8'h01, 8'h64};
      upd(0, 5, 8'h06);
      {cur[5], wst[5]} = {8'h06, 8'h06};
      stat();
      page(1);
      page(0);
      {cap_autosave, cap_save_powersave} = 2'b10;
      page(0);
      cmd(8'hD5);
      rd(sdpf_pkg::ADDR_ERR);
      `CHK("err_info", 8'h04, v)
      results();
   end
endmodule
